// ===== core/stfh_frame_handler.sv
// stfh_frame_handler: S/T frame build and parse for eight line channels on the serial frame link.
// assumes: classic Wishbone master on clk_i; link bit clock, frame sync and receive pair are pins.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module stfh_frame_handler
  import stfh_pkg::*;
#(
  parameter int NCH = STFH_NCH,
  parameter int TX_LEAD_BITS = STFH_UP_OFFSET_BITS
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_bit_clk_i,
  input wire logic frame_sync_i,
  input wire stfh_pkg::stfh_pair_s link_rx_i,
  output stfh_pkg::stfh_pair_s link_tx_o,
  output logic [7:0] collision_flag_o
);
  import stfh_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NCH != 8 || STFH_FRAME_BITS != 48) begin : g_bad_geom
    $error("stfh_frame_handler serves exactly eight channels of 48-bit frames");
  end
  if (TX_LEAD_BITS < 0 || TX_LEAD_BITS >= STFH_FRAME_BITS) begin : g_bad_lead
    $error("stfh_frame_handler transmit lead must lie within one frame");
  end

  localparam logic [8:0] LAST_SLOT = 9'(STFH_NCH * STFH_FRAME_BITS - 1);
  localparam logic [6:0] LEAD = 7'(TX_LEAD_BITS);

  // ----------------------------------------------------------------
  // pin synchronisation and strobes
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic clk_q, fs_q;
  stfh_sync #(.WIDTH(4)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({link_bit_clk_i, frame_sync_i, link_rx_i.ctl, link_rx_i.dat}),
    .q_o(pins_s)
  );
  wire logic bit_stb = pins_s[3] & ~clk_q;
  wire logic fs_rise = pins_s[2] & ~fs_q;
  stfh_pair_s rxp;
  assign rxp = '{ctl: pins_s[1], dat: pins_s[0]};

  // ----------------------------------------------------------------
  // state and data memory
  // ----------------------------------------------------------------
  logic trunk, run;
  logic [7:0] echo_blk, coll, cpos, blocked;
  logic [8:0] slot;
  logic [7:0] tx_b1 [STFH_NCH];
  logic [7:0] tx_b2 [STFH_NCH];
  logic [7:0] tx_ctl [STFH_NCH];
  logic [7:0] rx_b1 [STFH_NCH];
  logic [7:0] rx_b2 [STFH_NCH];
  logic [7:0] rx_ctl [STFH_NCH];
  logic [5:0] rx_bit [STFH_NCH];
  logic [7:0] rx_lock, zpar, last_d;

  logic next_trunk, next_run, next_ack;
  logic [7:0] next_echo_blk, next_coll, next_cpos, next_blocked;
  logic [8:0] next_slot;
  logic [31:0] next_dat;
  stfh_pair_s next_tx;
  logic next_zp, next_ld, next_rl;
  logic [5:0] next_rb;
  logic [7:0] next_rb1, next_rb2, next_rctl;
  logic [7:0] next_tb1, next_tb2, next_tctl;
  logic [2:0] ch, wch;
  logic [5:0] bitn, txb, rb;
  logic [6:0] lead_sum;
  logic [1:0] tq, rq;
  stfh_field_e tf, rf;
  logic tv, req, wr, tx_hit;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    ch = slot[2:0];
    bitn = slot[8:3];
    lead_sum = {1'b0, bitn} + LEAD;
    if (lead_sum >= 7'(STFH_FRAME_BITS)) lead_sum = lead_sum - 7'(STFH_FRAME_BITS);
    txb = trunk ? lead_sum[5:0] : bitn;
    tf = stfh_field(txb, trunk);
    tq = stfh_quarter(txb);
    rb = rx_bit[ch];
    rf = stfh_field(rb, ~trunk);
    rq = stfh_quarter(rb);
    req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr = req & wb_we_i;
    wch = wb_adr_i[4:2];
    tx_hit = wr && wb_adr_i[7:5] == STFH_REG_TX_BASE[7:5];
    tv = 1'b1;

    next_trunk = trunk;
    next_run = run;
    next_echo_blk = echo_blk;
    next_ack = req;
    next_dat = wb_dat_o;
    next_slot = slot;
    next_tx = link_tx_o;
    next_zp = zpar[ch];
    next_ld = last_d[ch];
    next_rl = rx_lock[ch];
    next_rb = rb;
    next_rb1 = rx_b1[ch];
    next_rb2 = rx_b2[ch];
    next_rctl = rx_ctl[ch];
    next_coll = coll;
    next_cpos = cpos;
    next_blocked = blocked;
    next_tb1 = tx_b1[wch];
    next_tb2 = tx_b2[wch];
    next_tctl = tx_ctl[wch];

    // bus side: clears first so that a same-cycle hardware set wins
    if (wr && wb_adr_i == STFH_REG_CTRL && wb_sel_i[0]) begin
      next_trunk = wb_dat_i[STFH_CTRL_MODE_BIT];
      next_run = wb_dat_i[STFH_CTRL_RUN_BIT];
    end
    if (wr && wb_adr_i == STFH_REG_ECHO && wb_sel_i[0]) next_echo_blk = wb_dat_i[7:0];
    if (wr && wb_adr_i == STFH_REG_STAT && wb_sel_i[0]) next_coll = coll & ~wb_dat_i[7:0];
    if (wr && wb_adr_i == STFH_REG_DEN && wb_sel_i[0]) begin
      next_blocked = blocked & ~wb_dat_i[7:0];
    end
    if (tx_hit) begin
      if (wb_sel_i[0]) next_tb1 = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_tb2 = wb_dat_i[15:8];
      if (wb_sel_i[2]) next_tctl = wb_dat_i[23:16];
    end
    if (req && !wb_we_i) begin
      next_dat = '0;
      if (wb_adr_i == STFH_REG_CTRL) next_dat[1:0] = {run, trunk};
      else if (wb_adr_i == STFH_REG_STAT) next_dat[15:0] = {cpos, coll};
      else if (wb_adr_i == STFH_REG_ECHO) next_dat[7:0] = echo_blk;
      else if (wb_adr_i == STFH_REG_DEN) next_dat[7:0] = blocked;
      else if (wb_adr_i[7:5] == STFH_REG_TX_BASE[7:5])
        next_dat[23:0] = {tx_ctl[wch], tx_b2[wch], tx_b1[wch]};
      else if (wb_adr_i[7:5] == STFH_REG_RX_BASE[7:5])
        next_dat = {cpos[wch], coll[wch], 6'h00, rx_ctl[wch], rx_b2[wch], rx_b1[wch]};
    end

    if (fs_rise) begin
      next_slot = '0;
    end else if (bit_stb && run) begin
      // slot order: bit n of channels 0..7, then bit n+1
      next_slot = (slot == LAST_SLOT) ? 9'h000 : slot + 9'h001;

      // transmit pair for this channel and bit
      next_tx = '{ctl: 1'b0, dat: 1'b1};
      unique case (tf)
        STFH_F_FRAME: next_tx = STFH_PAIR_FRAME;
        STFH_F_BAL: begin
          next_tx.dat = ~zpar[ch];
          next_zp = 1'b0;
        end
        STFH_F_B1: tv = tx_b1[ch][stfh_bbit(txb)];
        STFH_F_B2: tv = tx_b2[ch][stfh_bbit(txb)];
        // transceiver reflects D itself; we only say whether to invert
        STFH_F_ECHO: next_tx.dat = echo_blk[ch];
        STFH_F_D: begin
          // blocked channel sends ones in trunk mode; ones never win over zeros on D
          tv = (trunk && blocked[ch]) ? 1'b1 : tx_ctl[ch][STFH_CTL_D_LSB + int'(tq)];
          next_ld = tv;
        end
        STFH_F_ACT: tv = tx_ctl[ch][STFH_CTL_A];
        STFH_F_AUX: tv = tx_ctl[ch][STFH_CTL_FA];
        STFH_F_NINV: tv = ~tx_ctl[ch][STFH_CTL_FA];
        STFH_F_MULTI: tv = tx_ctl[ch][STFH_CTL_M];
        STFH_F_SCH: tv = tx_ctl[ch][STFH_CTL_S];
      endcase
      if (tf != STFH_F_FRAME && tf != STFH_F_BAL && tf != STFH_F_ECHO) begin
        next_tx.dat = tv;
        if (!tv) next_zp = ~zpar[ch];
      end

      // receive: each channel finds its own frame start
      if (rxp == STFH_PAIR_FRAME) begin
        next_rb = 6'd1;
        next_rl = 1'b1;
      end else if (rx_lock[ch]) begin
        next_rb = (rb == STFH_LAST_BIT) ? 6'd0 : rb + 6'd1;
        unique case (rf)
          STFH_F_B1: next_rb1[stfh_bbit(rb)] = rxp.dat;
          STFH_F_B2: next_rb2[stfh_bbit(rb)] = rxp.dat;
          STFH_F_D: next_rctl[STFH_CTL_D_LSB + int'(rq)] = rxp.dat;
          STFH_F_AUX: next_rctl[STFH_CTL_FA] = rxp.dat;
          STFH_F_ACT: next_rctl[STFH_CTL_A] = rxp.dat;
          STFH_F_MULTI: next_rctl[STFH_CTL_M] = rxp.dat;
          STFH_F_SCH: next_rctl[STFH_CTL_S] = rxp.dat;
          STFH_F_ECHO: begin
            if (rxp.dat != last_d[ch]) begin
              next_coll[ch] = 1'b1;
              next_cpos[ch] = rq[0];
              next_blocked[ch] = 1'b1;
            end
          end
          default: next_rl = 1'b1; // framing, balance and N bits are dropped
        endcase
      end
    end
    // a stopped link shows the idle pair, not the last bit sent
    if (!run) next_tx = STFH_PAIR_IDLE;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {run, trunk} <= STFH_CTRL_RST;
      echo_blk <= STFH_MASK_RST;
      coll <= STFH_MASK_RST;
      cpos <= STFH_MASK_RST;
      blocked <= STFH_MASK_RST;
      collision_flag_o <= STFH_MASK_RST;
      slot <= '0;
      clk_q <= 1'b0;
      fs_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      link_tx_o <= STFH_PAIR_IDLE;
      rx_lock <= STFH_MASK_RST;
      zpar <= STFH_MASK_RST;
      last_d <= 8'hff;
      for (int i = 0; i < STFH_NCH; i++) begin
        tx_b1[i] <= 8'hff;
        tx_b2[i] <= 8'hff;
        tx_ctl[i] <= 8'hf0;
        rx_b1[i] <= 8'h00;
        rx_b2[i] <= 8'h00;
        rx_ctl[i] <= 8'h00;
        rx_bit[i] <= 6'd0;
      end
    end else begin
      trunk <= next_trunk;
      run <= next_run;
      echo_blk <= next_echo_blk;
      coll <= next_coll;
      cpos <= next_cpos;
      blocked <= next_blocked;
      collision_flag_o <= next_coll;
      slot <= next_slot;
      clk_q <= pins_s[3];
      fs_q <= pins_s[2];
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      link_tx_o <= next_tx;
      zpar[ch] <= next_zp;
      last_d[ch] <= next_ld;
      rx_lock[ch] <= next_rl;
      rx_bit[ch] <= next_rb;
      rx_b1[ch] <= next_rb1;
      rx_b2[ch] <= next_rb2;
      rx_ctl[ch] <= next_rctl;
      tx_b1[wch] <= next_tb1;
      tx_b2[wch] <= next_tb2;
      tx_ctl[wch] <= next_tctl;
    end
  end
endmodule : stfh_frame_handler

// ===== core/stfh_pkg.sv
// stfh_pkg: constants, register map, frame layout and link carrier for the S/T frame handler.
// assumes: shared by stfh_frame_handler and the bench; no state of its own.
package stfh_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int STFH_NCH = 8;
  localparam int STFH_LINE_RATE_KBPS = 192;
  localparam int STFH_FRAME_BITS = 48;
  localparam int STFH_USER_BITS = 36;
  localparam int STFH_OVH_BITS = 12;
  localparam int STFH_UP_OFFSET_BITS = 2;
  localparam logic [5:0] STFH_LAST_BIT = 6'd47;

  // ----------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STFH_REG_CTRL = 8'h00;
  localparam logic [7:0] STFH_REG_STAT = 8'h04;
  localparam logic [7:0] STFH_REG_ECHO = 8'h08;
  localparam logic [7:0] STFH_REG_DEN = 8'h0c;
  localparam logic [7:0] STFH_REG_TX_BASE = 8'h40;
  localparam logic [7:0] STFH_REG_RX_BASE = 8'h60;
  localparam int STFH_CTRL_MODE_BIT = 0;
  localparam int STFH_CTRL_RUN_BIT = 1;
  localparam logic [1:0] STFH_CTRL_RST = 2'b00;
  localparam logic [7:0] STFH_MASK_RST = 8'h00;
  // ctl byte of a channel word: [7:4] D bits, [3] Fa, [2] M, [1] S, [0] A
  localparam int STFH_CTL_D_LSB = 4;
  localparam int STFH_CTL_FA = 3;
  localparam int STFH_CTL_M = 2;
  localparam int STFH_CTL_S = 1;
  localparam int STFH_CTL_A = 0;

  // ----------------------------------------------------------------
  // link carrier and frame fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ctl;
    logic dat;
  } stfh_pair_s;

  localparam stfh_pair_s STFH_PAIR_FRAME = '{ctl: 1'b1, dat: 1'b1};
  localparam stfh_pair_s STFH_PAIR_IDLE = '{ctl: 1'b0, dat: 1'b1};

  typedef enum {
    STFH_F_FRAME, STFH_F_BAL, STFH_F_B1, STFH_F_B2, STFH_F_ECHO, STFH_F_D,
    STFH_F_ACT, STFH_F_AUX, STFH_F_NINV, STFH_F_MULTI, STFH_F_SCH
  } stfh_field_e;

  // field at a bit position; up selects the terminal-to-network layout
  function automatic stfh_field_e stfh_field(input logic [5:0] b, input logic up);
    stfh_field_e f;
    f = STFH_F_BAL;
    if (b == 6'd0) f = STFH_F_FRAME;
    else if ((b >= 6'd2 && b <= 6'd9) || (b >= 6'd26 && b <= 6'd33)) f = STFH_F_B1;
    else if ((b >= 6'd15 && b <= 6'd22) || (b >= 6'd37 && b <= 6'd44)) f = STFH_F_B2;
    else if (b == 6'd11 || b == 6'd24 || b == 6'd35 || b == 6'd46) f = STFH_F_D;
    else if (b == 6'd13) f = STFH_F_AUX;
    else if (!up) begin
      if (b == 6'd10 || b == 6'd23 || b == 6'd34 || b == 6'd45) f = STFH_F_ECHO;
      else if (b == 6'd12) f = STFH_F_ACT;
      else if (b == 6'd14) f = STFH_F_NINV;
      else if (b == 6'd25) f = STFH_F_MULTI;
      else if (b == 6'd36) f = STFH_F_SCH;
    end
    return f;
  endfunction : stfh_field

  // quarter of the frame (one B octet, one D bit, one E bit each)
  function automatic logic [1:0] stfh_quarter(input logic [5:0] b);
    logic [1:0] q;
    q = 2'd3;
    if (b < 6'd13) q = 2'd0;
    else if (b < 6'd26) q = 2'd1;
    else if (b < 6'd37) q = 2'd2;
    return q;
  endfunction : stfh_quarter

  // octet bit carried at a B position, msb first on the line
  function automatic logic [2:0] stfh_bbit(input logic [5:0] b);
    logic [5:0] s;
    s = 6'd37;
    if (b < 6'd13) s = 6'd2;
    else if (b < 6'd26) s = 6'd15;
    else if (b < 6'd37) s = 6'd26;
    return 3'd7 - 3'(b - s);
  endfunction : stfh_bbit

endpackage : stfh_pkg

// ===== core/stfh_sync.sv
// stfh_sync: three-stage synchroniser with agreement filter for pin inputs.
// assumes: inputs are asynchronous to clk_i; output changes once stages two and three agree.
`timescale 1ns/1ns
module stfh_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] s1, s2, s3;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_q = q_o;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) next_q[i] = s3[i];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_o <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= next_q;
    end
  end
endmodule : stfh_sync

// ===== tb/stfh_monitor.sv
// stfh_monitor: bus and link port assertions for stfh_frame_handler.
// assumes: bound to the top module; one clock, async active-high reset.
`timescale 1ns/1ns
module stfh_monitor (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic link_bit_clk_i,
  input wire stfh_pkg::stfh_pair_s link_tx_o,
  input wire logic [7:0] collision_flag_o
);
  import stfh_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // --------------------------------------------------------------
  // ages: cycles since a link clock rise and since a taken write
  // --------------------------------------------------------------
  logic lclk_q;
  logic [7:0] lclk_age, next_lclk_age, wr_age, next_wr_age;
  logic stat_wr;
  assign stat_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == STFH_REG_STAT;
  always_comb begin
    next_lclk_age = (lclk_age == 8'hff) ? lclk_age : lclk_age + 8'h01;
    if (link_bit_clk_i && !lclk_q) next_lclk_age = 8'h00;
    next_wr_age = (wr_age == 8'hff) ? wr_age : wr_age + 8'h01;
    if (wb_cyc_i && wb_stb_i && wb_we_i) next_wr_age = 8'h00;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lclk_q <= 1'b0;
      lclk_age <= 8'hff;
      wr_age <= 8'hff;
    end else begin
      lclk_q <= link_bit_clk_i;
      lclk_age <= next_lclk_age;
      wr_age <= next_wr_age;
    end
  end
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_dat_hold: assert property (!$stable(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
    else $error("read data changed outside a read answer");
  a_reset_idle: assert property ($fell(sys_rst_i) |->
    link_tx_o == STFH_PAIR_IDLE && collision_flag_o == 8'h00 && !wb_ack_o)
    else $error("outputs not idle after reset");
  a_tx_quiet: assert property (lclk_age > 8'd12 && wr_age > 8'd4 |-> $stable(link_tx_o))
    else $error("link pair changed without a link clock edge");
  a_flag_set: assert property (|(collision_flag_o & ~$past(collision_flag_o)) |->
    lclk_age < 8'd14)
    else $error("collision flag set away from a link slot");
  a_flag_sticky: assert property (|($past(collision_flag_o) & ~collision_flag_o) |->
    $past(stat_wr))
    else $error("collision flag dropped without a status write");
endmodule : stfh_monitor

// ===== tb/stfh_line_model.sv
// stfh_line_model: line chip on the serial frame link, n frames per run(n) call.
// assumes: run is called just after a rising clk_i edge; clock stops between runs.
`timescale 1ns/1ns
module stfh_line_model (
  input wire logic clk_i,
  input wire stfh_pkg::stfh_pair_s tx_i,
  output logic lclk_o,
  output logic fs_o,
  output stfh_pkg::stfh_pair_s rx_o
);
  import stfh_pkg::*;
  stfh_pair_s rx_mem [384];
  stfh_pair_s tx_cap [384];
  initial begin
    lclk_o = 1'b0;
    fs_o = 1'b0;
    rx_o = STFH_PAIR_IDLE;
  end
  // rx changes mid-period so it is settled at the link clock rise
  task automatic run(input int n);
    for (int f = 0; f < n; f++) begin
      fs_o <= 1'b1;
      repeat (10) @(posedge clk_i);
      fs_o <= 1'b0;
      for (int s = 0; s < 384; s++) begin
        rx_o <= rx_mem[s];
        repeat (10) @(posedge clk_i);
        lclk_o <= 1'b1;
        repeat (10) @(posedge clk_i);
        tx_cap[s] = tx_i;
        lclk_o <= 1'b0;
      end
    end
    rx_o <= ~rx_o;
  endtask : run
endmodule : stfh_line_model

// ===== tb/tb.sv
// tb: self-checking bench for stfh_frame_handler with a line chip model.
// assumes: bus tasks start right after a rising edge; the model owns the link pins.
`timescale 1ns/1ns
module tb;
  import stfh_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] rdat, q;
  logic wb_ack, lclk, fsync;
  logic [7:0] coll;
  logic [7:0] pat = 8'h5a;
  stfh_pair_s rx, tx;
  int fail_count = 0;
  int n_compared = 0;
  int off = 0;
  int ep [4] = '{10, 23, 34, 45};
  // ctl, B2, B1 per channel
  logic [23:0] rows [8] = '{24'hf0ffff, 24'h0f00a5, 24'h3c5a3c, 24'ha9817e,
    24'hc20ff0, 24'h15ee11, 24'hf81234, 24'h07c396};
  always #4 clk_i = ~clk_i;
  stfh_frame_handler dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(wb_ack), .link_bit_clk_i(lclk),
    .frame_sync_i(fsync), .link_rx_i(rx), .link_tx_o(tx), .collision_flag_o(coll));
  stfh_line_model line_u (.clk_i(clk_i), .tx_i(tx), .lclk_o(lclk), .fs_o(fsync),
    .rx_o(rx));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (n < 20 && wb_ack !== 1'b1);
    if (wb_ack !== 1'b1) begin
      $display("[FAIL] wb ack expected 1 seen %b", wb_ack);
      fail_count++;
      print_verdict();
    end else begin
      q = rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask : wb
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rdc
  task automatic pc(input string nm, input int s, input logic [1:0] e);
    chk(nm, {30'h0, e}, {30'h0, line_u.tx_cap[s]});
  endtask : pc
  task automatic setrx(input int c, input int b, input logic [1:0] p);
    line_u.rx_mem[((b + off) % 48) * 8 + c] = p;
  endtask : setrx
  task automatic fill();
    for (int s = 0; s < 384; s++) line_u.rx_mem[s] = STFH_PAIR_IDLE;
    for (int c = 0; c < 8; c++) setrx(c, 0, STFH_PAIR_FRAME);
  endtask : fill
  // expected downstream pair {ctl, dat} at frame bit b
  function automatic logic [1:0] exp_dn(input logic [23:0] w, input logic e, input int b);
    logic [7:0] c;
    int z;
    c = w[23:16];
    z = $countones(~{c[7:4], c[2:0]}) + 1;
    case (b)
      0: return 2'b11;
      1: return 2'b01;
      10, 23, 34, 45: return {1'b0, e};
      11: return {1'b0, c[4]};
      24: return {1'b0, c[5]};
      35: return {1'b0, c[6]};
      46: return {1'b0, c[7]};
      12: return {1'b0, c[0]};
      13: return {1'b0, c[3]};
      14: return {1'b0, ~c[3]};
      25: return {1'b0, c[2]};
      36: return {1'b0, c[1]};
      47: return {1'b0, ~z[0]};
      default: return {1'b0, b < 13 ? w[9 - b] : b < 26 ? w[30 - b] :
        b < 37 ? w[33 - b] : w[52 - b]};
    endcase
  endfunction : exp_dn
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk("tx idle", {30'h0, STFH_PAIR_IDLE}, {30'h0, tx});
    rdc("ctrl", STFH_REG_CTRL, 32'h0);
    rdc("stat", STFH_REG_STAT, 32'h0);
    rdc("echo", STFH_REG_ECHO, 32'h0);
    rdc("den", STFH_REG_DEN, 32'h0);
    rdc("tx word", STFH_REG_TX_BASE, 32'h00f0ffff);
    wb(1'b1, 8'h10, 32'hffffffff);
    rdc("unmapped", 8'h10, 32'h0);
    // byte lanes: only the B2 lane of channel 7 may change
    wb_sel <= 4'h2;
    wb(1'b1, STFH_REG_TX_BASE + 8'h1c, 32'h00123456);
    wb_sel <= 4'hf;
    rdc("tx lane", STFH_REG_TX_BASE + 8'h1c, 32'h00f034ff);
    $display("reset test done");
    for (int c = 0; c < 8; c++) wb(1'b1, STFH_REG_TX_BASE + 8'(4 * c), {8'h00, rows[c]});
    wb(1'b1, STFH_REG_ECHO, 32'h81);
    off = 2;
    fill();
    for (int i = 0; i < 8; i++) setrx(2, 2 + i, {1'b0, pat[7 - i]});
    for (int i = 0; i < 8; i++) setrx(2, 26 + i, {1'b0, pat[7 - i]});
    wb(1'b1, STFH_REG_CTRL, 32'h2);
    line_u.run(2);
    for (int c = 0; c < 8; c++)
      for (int b = 0; b < 48; b++)
        pc("net tx pair", b * 8 + c, exp_dn(rows[c], c == 0 || c == 7, b));
    wb(1'b0, STFH_REG_RX_BASE + 8'h08, 32'h0);
    chk("net rx word", 32'h00f8ff5a, q & 32'h00f8ffff);
    $display("network test done");
    for (int c = 0; c < 8; c++)
      wb(1'b1, STFH_REG_TX_BASE + 8'(4 * c), (c == 3 || c == 5) ? 32'h0000ffff : 32'h00f0ffff);
    off = 0;
    fill();
    setrx(3, 10, 2'b00);
    wb(1'b1, STFH_REG_CTRL, 32'h3);
    line_u.run(1);
    chk("coll flags", 32'h28, {24'h0, coll});
    rdc("stat", STFH_REG_STAT, 32'h0828);
    rdc("den mask", STFH_REG_DEN, 32'h28);
    pc("trunk frame bit", 368, 2'b11);
    pc("d before", 75, 2'b00);
    pc("d blocked", 267, 2'b01);
    pc("d blocked", 181, 2'b01);
    repeat (200) @(posedge clk_i);
    chk("coll held", 32'h28, {24'h0, coll});
    wb(1'b1, STFH_REG_STAT, 32'h08);
    wb(1'b1, STFH_REG_DEN, 32'h20);
    chk("coll cleared", 32'h20, {24'h0, coll});
    rdc("den mask", STFH_REG_DEN, 32'h08);
    fill();
    foreach (ep[i]) setrx(5, ep[i], 2'b00);
    line_u.run(1);
    pc("d enabled", 77, 2'b00);
    pc("d still blocked", 75, 2'b01);
    chk("coll flags", 32'h20, {24'h0, coll});
    $display("trunk test done");
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("reset flags", 32'h0, {24'h0, coll});
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("den", STFH_REG_DEN, 32'h0);
    $display("second reset test done");
    print_verdict();
  end
endmodule : tb
bind stfh_frame_handler stfh_monitor mon_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_bit_clk_i(link_bit_clk_i),
  .link_tx_o(link_tx_o), .collision_flag_o(collision_flag_o));
